// [pei_pkg.sv]
// Package with register map, field positions and reset values for the port event interrupt block.
package pei_pkg;
   localparam int unsigned NUM_PORTS      = 8;
   localparam int unsigned PORT_IDX_W     = 3;
   localparam int unsigned REG_IDX_W      = 3;
   // Register indices per port; byte address is 32*port + 4*index.
   localparam logic [REG_IDX_W-1:0] IDX_SUMMARY   = 3'h0;
   localparam logic [REG_IDX_W-1:0] IDX_FLAGS     = 3'h1;
   localparam logic [REG_IDX_W-1:0] IDX_MASK      = 3'h2;
   localparam logic [REG_IDX_W-1:0] IDX_STOPCAUSE = 3'h3;
   localparam logic [REG_IDX_W-1:0] IDX_RXCAUSE   = 3'h4;
   localparam logic [REG_IDX_W-1:0] IDX_TXPOLICY  = 3'h5;
   localparam logic [REG_IDX_W-1:0] IDX_RXPOLICY  = 3'h6;
   localparam logic [REG_IDX_W-1:0] IDX_CONTROL   = 3'h7;
   localparam int unsigned ADDR_IDX_LSB   = 2;
   localparam int unsigned ADDR_PORT_LSB  = 5;
   localparam int unsigned ADDR_USED_MSB  = 7;
   // Event flag bit positions.
   localparam int unsigned FLG_RX_GOOD    = 0;
   localparam int unsigned FLG_RX_CAUSE   = 1;
   localparam int unsigned FLG_TX_DONE    = 2;
   localparam int unsigned FLG_TX_FAULT   = 3;
   localparam int unsigned FLG_LINK       = 4;
   localparam int unsigned FLG_SATURATED  = 5;
   localparam int unsigned FLG_HALTED     = 6;
   // Stop cause bit positions.
   localparam int unsigned SC_STARVED     = 0;
   localparam int unsigned SC_LATE_COL    = 1;
   localparam int unsigned SC_EXCESS_COL  = 2;
   localparam int unsigned SC_PKC_LSB     = 6;
   // Control register bit positions.
   localparam int unsigned CTL_RX_EN      = 3;
   localparam int unsigned CTL_TX_EN      = 4;
   localparam logic [7:0] MASK_VALID      = 8'h7f;
   localparam logic [7:0] SC_ERR_BITS     = 8'h07;
   localparam logic [7:0] RX_CAUSE_VALID  = 8'hbf;
   localparam logic [7:0] REG_RESET       = 8'h00;
   localparam logic [1:0] PKC_MAX         = 2'h2;
   localparam logic [31:0] RDATA_ZERO     = 32'h0000_0000;
endpackage

// [pei_top.sv]
// Per-port event flags, masks, transmit stop causes and a chip summary behind an APB slave.
`timescale 1ns/1ps
module pei_top
   import pei_pkg::*;
(
   input  wire logic                 i_clock,
   input  wire logic                 i_rstn,
   input  wire logic                 i_psel,
   input  wire logic                 i_penable,
   input  wire logic                 i_pwrite,
   input  wire logic [31:0]          i_paddr,
   input  wire logic [31:0]          i_pwdata,
   output      logic [31:0]          o_prdata,
   output      logic                 o_pready,
   output      logic                 o_pslverr,
   input  wire logic [NUM_PORTS-1:0] i_rx_good_done,
   input  wire logic [NUM_PORTS-1:0] i_rx_pkt_end,
   input  wire logic [7:0]           i_rx_cause [NUM_PORTS],
   input  wire logic [NUM_PORTS-1:0] i_tx_done,
   input  wire logic [NUM_PORTS-1:0] i_tx_excess_col,
   input  wire logic [NUM_PORTS-1:0] i_tx_late_col,
   input  wire logic [NUM_PORTS-1:0] i_tx_starved,
   input  wire logic [NUM_PORTS-1:0] i_tx_fifo_first_byte,
   input  wire logic [NUM_PORTS-1:0] i_tx_idle,
   input  wire logic [NUM_PORTS-1:0] i_rx_idle,
   input  wire logic [NUM_PORTS-1:0] i_counter_saturated,
   input  wire logic [NUM_PORTS-1:0] i_link_changed,
   input  wire logic [NUM_PORTS-1:0] i_symbol_link_mode,
   output      logic [NUM_PORTS-1:0] o_transmit_path_enable,
   output      logic [NUM_PORTS-1:0] o_receive_path_enable,
   output      logic [7:0]           o_receive_filter_policy [NUM_PORTS],
   output      logic                 o_irq
);

   logic [7:0]           flags_q [NUM_PORTS];
   logic [7:0]           mask_q [NUM_PORTS];
   logic [7:0]           cause_q [NUM_PORTS];
   logic [7:0]           rxc_q [NUM_PORTS];
   logic [7:0]           txpol_q [NUM_PORTS];
   logic [7:0]           rxpol_q [NUM_PORTS];
   logic [7:0]           ctl_q [NUM_PORTS];
   logic [1:0]           pkc_q [NUM_PORTS];
   logic [NUM_PORTS-1:0] halted_q;
   logic [NUM_PORTS-1:0] summary;
   logic [31:0]          prdata_q;

   logic                  acc;
   logic                  wr;
   logic                  rd;
   logic [PORT_IDX_W-1:0] sel_port;
   logic [REG_IDX_W-1:0]  sel_idx;
   logic                  addr_bad;

   function automatic logic rd_hit(input logic r, input logic [PORT_IDX_W-1:0] sp, input int unsigned p,
                                   input logic [REG_IDX_W-1:0] si, input logic [REG_IDX_W-1:0] want);
      rd_hit = r && (sp == PORT_IDX_W'(p)) && (si == want);
   endfunction

   assign acc      = i_psel && i_penable;
   assign wr       = acc && i_pwrite;
   assign rd       = acc && !i_pwrite;
   assign sel_port = i_paddr[ADDR_PORT_LSB +: PORT_IDX_W];
   assign sel_idx  = i_paddr[ADDR_IDX_LSB +: REG_IDX_W];
   assign addr_bad = (i_paddr[31:ADDR_USED_MSB+1] != '0) || (i_paddr[1:0] != 2'h0)
                     || ((sel_idx == IDX_SUMMARY) && (sel_port != '0));
   assign o_pready  = 1'b1;
   assign o_pslverr = acc && addr_bad;
   assign o_prdata  = prdata_q;

   // Read data is captured during setup so it appears with the zero-wait access phase.
   always_ff @(posedge i_clock or negedge i_rstn) begin
      if (!i_rstn) begin
         prdata_q <= RDATA_ZERO;
      end else if (i_psel && !i_penable && !i_pwrite) begin
         prdata_q <= RDATA_ZERO;
         if (!addr_bad) begin
            case (sel_idx)
               IDX_SUMMARY:   prdata_q[7:0] <= summary;
               IDX_FLAGS:     prdata_q[7:0] <= flags_q[sel_port];
               IDX_MASK:      prdata_q[7:0] <= mask_q[sel_port];
               IDX_STOPCAUSE: prdata_q[7:0] <= {pkc_q[sel_port], cause_q[sel_port][5:0]};
               IDX_RXCAUSE:   prdata_q[7:0] <= rxc_q[sel_port];
               IDX_TXPOLICY:  prdata_q[7:0] <= txpol_q[sel_port];
               IDX_RXPOLICY:  prdata_q[7:0] <= rxpol_q[sel_port];
               IDX_CONTROL:   prdata_q[7:0] <= ctl_q[sel_port];
               default:       prdata_q <= RDATA_ZERO;
            endcase
         end
      end
   end

   generate
      for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
         logic rd_flags;
         logic rd_cause;
         logic rd_rxc;
         logic wsel;
         logic halt_now;
         logic [7:0] ev;
         logic [7:0] cause_set;
         assign rd_flags = rd_hit(rd && !addr_bad, sel_port, p, sel_idx, IDX_FLAGS);
         assign rd_cause = rd_hit(rd && !addr_bad, sel_port, p, sel_idx, IDX_STOPCAUSE);
         assign rd_rxc   = rd_hit(rd && !addr_bad, sel_port, p, sel_idx, IDX_RXCAUSE);
         assign wsel     = wr && !addr_bad && (sel_port == PORT_IDX_W'(p));

         // A path counts as stopped when it is disabled and its current packet has finished.
         assign halt_now = (!ctl_q[p][CTL_TX_EN] || !ctl_q[p][CTL_RX_EN])
                           && (ctl_q[p][CTL_TX_EN] || i_tx_idle[p])
                           && (ctl_q[p][CTL_RX_EN] || i_rx_idle[p]);

         assign cause_set = {5'h00,
                             i_tx_excess_col[p] && txpol_q[p][SC_EXCESS_COL],
                             i_tx_late_col[p]   && txpol_q[p][SC_LATE_COL],
                             i_tx_starved[p]    && txpol_q[p][SC_STARVED]};

         always_comb begin
            ev = 8'h00;
            ev[FLG_RX_GOOD]   = i_rx_good_done[p];
            ev[FLG_TX_DONE]   = i_tx_done[p];
            ev[FLG_LINK]      = i_link_changed[p] && i_symbol_link_mode[p];
            ev[FLG_SATURATED] = i_counter_saturated[p];
            ev[FLG_HALTED]    = halt_now && !halted_q[p];
         end

         always_ff @(posedge i_clock or negedge i_rstn) begin
            if (!i_rstn) begin
               halted_q[p] <= 1'b0;
            end else begin
               halted_q[p] <= halt_now;
            end
         end

         // Flags: FLG_RX_CAUSE and FLG_TX_FAULT mirror the cause registers; for the others a read clears only the bits it returned, and a same-cycle event wins.
         always_ff @(posedge i_clock or negedge i_rstn) begin
            if (!i_rstn) begin
               flags_q[p] <= REG_RESET;
            end else begin
               for (int b = 0; b < 8; b++) begin
                  if (b == FLG_TX_FAULT) begin
                     flags_q[p][b] <= mask_q[p][b] && ((cause_q[p] & SC_ERR_BITS) != 8'h00);
                  end else if (b == FLG_RX_CAUSE) begin
                     flags_q[p][b] <= mask_q[p][b] && (rxc_q[p] != 8'h00);
                  end else if (ev[b] && mask_q[p][b]) begin
                     flags_q[p][b] <= 1'b1;
                  end else if (rd_flags && prdata_q[b]) begin
                     flags_q[p][b] <= 1'b0;
                  end
               end
            end
         end

         always_ff @(posedge i_clock or negedge i_rstn) begin
            if (!i_rstn) begin
               mask_q[p]  <= REG_RESET;
               txpol_q[p] <= REG_RESET;
               rxpol_q[p] <= REG_RESET;
               ctl_q[p]   <= REG_RESET;
            end else if (wsel) begin
               case (sel_idx)
                  IDX_MASK:     mask_q[p]  <= i_pwdata[7:0] & MASK_VALID;
                  IDX_TXPOLICY: txpol_q[p] <= i_pwdata[7:0];
                  IDX_RXPOLICY: rxpol_q[p] <= i_pwdata[7:0];
                  IDX_CONTROL:  ctl_q[p]   <= i_pwdata[7:0];
                  default:      mask_q[p]  <= mask_q[p];
               endcase
            end
         end

         always_ff @(posedge i_clock or negedge i_rstn) begin
            if (!i_rstn) begin
               cause_q[p] <= REG_RESET;
            end else if (rd_cause) begin
               cause_q[p] <= (cause_q[p] & ~(prdata_q[7:0] & SC_ERR_BITS)) | cause_set;
            end else begin
               cause_q[p] <= cause_q[p] | cause_set;
            end
         end

         always_ff @(posedge i_clock or negedge i_rstn) begin
            if (!i_rstn) begin
               rxc_q[p] <= REG_RESET;
            end else if (i_rx_pkt_end[p]) begin
               rxc_q[p] <= (rd_rxc ? (rxc_q[p] & ~prdata_q[7:0]) : rxc_q[p])
                           | (i_rx_cause[p] & RX_CAUSE_VALID);
            end else if (rd_rxc) begin
               rxc_q[p] <= rxc_q[p] & ~prdata_q[7:0];
            end
         end

         always_ff @(posedge i_clock or negedge i_rstn) begin
            if (!i_rstn) begin
               pkc_q[p] <= 2'h0;
            end else if (i_tx_fifo_first_byte[p] && !i_tx_done[p] && pkc_q[p] != PKC_MAX) begin
               pkc_q[p] <= pkc_q[p] + 2'h1;
            end else if (i_tx_done[p] && !i_tx_fifo_first_byte[p] && pkc_q[p] != 2'h0) begin
               pkc_q[p] <= pkc_q[p] - 2'h1;
            end
         end

         assign summary[p]                 = flags_q[p] != 8'h00;
         assign o_transmit_path_enable[p]  = ctl_q[p][CTL_TX_EN];
         assign o_receive_path_enable[p]   = ctl_q[p][CTL_RX_EN];
         assign o_receive_filter_policy[p] = rxpol_q[p];

         sat_flag_a: assert property (@(posedge i_clock) disable iff (!i_rstn)
            (i_counter_saturated[p] && mask_q[p][FLG_SATURATED]) |=> flags_q[p][FLG_SATURATED])
            else $error("saturation flag not set");
         mask_gate_a: assert property (@(posedge i_clock) disable iff (!i_rstn)
            (!mask_q[p][FLG_TX_DONE] && !flags_q[p][FLG_TX_DONE]) |=> !flags_q[p][FLG_TX_DONE])
            else $error("masked event set a flag");
         read_clear_a: assert property (@(posedge i_clock) disable iff (!i_rstn)
            (rd_flags && prdata_q[FLG_RX_GOOD] && !ev[FLG_RX_GOOD]) |=> !flags_q[p][FLG_RX_GOOD])
            else $error("flag survived read");
         txf_or_a: assert property (@(posedge i_clock) disable iff (!i_rstn)
            (mask_q[p][FLG_TX_FAULT] && $stable(mask_q[p])) |->
            (flags_q[p][FLG_TX_FAULT] == ($past(cause_q[p]) != 8'h00)))
            else $error("tx fault flag mismatch");
         pkc_limit_a: assert property (@(posedge i_clock) disable iff (!i_rstn)
            pkc_q[p] <= PKC_MAX)
            else $error("packet count over limit");
         cause_keep_a: assert property (@(posedge i_clock) disable iff (!i_rstn)
            rd_cause |=> (pkc_q[p] == $past(pkc_q[p])) || $past(i_tx_done[p] || i_tx_fifo_first_byte[p]))
            else $error("cause read changed count");
         late_col_a: assert property (@(posedge i_clock) disable iff (!i_rstn)
            (i_tx_late_col[p] && txpol_q[p][SC_LATE_COL]) |=> cause_q[p][SC_LATE_COL])
            else $error("late collision not recorded");
         policy_a: assert property (@(posedge i_clock) disable iff (!i_rstn)
            (!txpol_q[p][SC_STARVED] && !cause_q[p][SC_STARVED]) |=> !cause_q[p][SC_STARVED])
            else $error("starved cause set without policy");

         sequence s_good_rx;
            i_rx_good_done[p] && mask_q[p][FLG_RX_GOOD];
         endsequence
         sequence s_tx_ok;
            i_tx_done[p] && mask_q[p][FLG_TX_DONE];
         endsequence
         sequence s_link_ev;
            i_link_changed[p] && i_symbol_link_mode[p] && mask_q[p][FLG_LINK];
         endsequence
         sequence s_halt_ev;
            halt_now && !halted_q[p] && mask_q[p][FLG_HALTED];
         endsequence

         rx_good_a: assert property (@(posedge i_clock) disable iff (!i_rstn)
            s_good_rx |=> flags_q[p][FLG_RX_GOOD])
            else $error("good receive flag not set");
         tx_done_a: assert property (@(posedge i_clock) disable iff (!i_rstn)
            s_tx_ok |=> flags_q[p][FLG_TX_DONE])
            else $error("transmit done flag not set");
         tx_keep_a: assert property (@(posedge i_clock) disable iff (!i_rstn)
            (rd_flags ##0 s_tx_ok) |=> flags_q[p][FLG_TX_DONE])
            else $error("event lost during flag read");
         link_set_a: assert property (@(posedge i_clock) disable iff (!i_rstn)
            s_link_ev |=> flags_q[p][FLG_LINK])
            else $error("link flag not set");
         link_mode_a: assert property (@(posedge i_clock) disable iff (!i_rstn)
            (!flags_q[p][FLG_LINK] && !(i_link_changed[p] && i_symbol_link_mode[p])) |=> !flags_q[p][FLG_LINK])
            else $error("link flag set outside symbol mode");
         halt_set_a: assert property (@(posedge i_clock) disable iff (!i_rstn)
            s_halt_ev |=> flags_q[p][FLG_HALTED])
            else $error("halt flag not set");
         halt_once_a: assert property (@(posedge i_clock) disable iff (!i_rstn)
            (halted_q[p] && !flags_q[p][FLG_HALTED]) |=> !flags_q[p][FLG_HALTED])
            else $error("halt flag set again while stopped");
         halt_wait_a: assert property (@(posedge i_clock) disable iff (!i_rstn)
            (!ctl_q[p][CTL_TX_EN] && !i_tx_idle[p] && !flags_q[p][FLG_HALTED]) |=> !flags_q[p][FLG_HALTED])
            else $error("halt flagged before transmit finished");
         rx_cause_summary_flag_or_a: assert property (@(posedge i_clock) disable iff (!i_rstn)
            (mask_q[p][FLG_RX_CAUSE] && $stable(mask_q[p])) |->
            (flags_q[p][FLG_RX_CAUSE] == ($past(rxc_q[p]) != 8'h00)))
            else $error("receive event flag mismatch");
         txf_keep_a: assert property (@(posedge i_clock) disable iff (!i_rstn)
            (rd_flags && mask_q[p][FLG_TX_FAULT] && (cause_q[p] != 8'h00)) |=> flags_q[p][FLG_TX_FAULT])
            else $error("tx fault flag cleared by flag read");
         rx_cause_summary_flag_keep_a: assert property (@(posedge i_clock) disable iff (!i_rstn)
            (rd_flags && mask_q[p][FLG_RX_CAUSE] && (rxc_q[p] != 8'h00)) |=> flags_q[p][FLG_RX_CAUSE])
            else $error("receive event flag cleared by flag read");
         rxc_clear_a: assert property (@(posedge i_clock) disable iff (!i_rstn)
            (rd_rxc && !i_rx_pkt_end[p]) |=> ((rxc_q[p] & $past(prdata_q[7:0])) == 8'h00))
            else $error("receive cause survived read");
         cause_clear_a: assert property (@(posedge i_clock) disable iff (!i_rstn)
            (rd_cause && (cause_set == 8'h00)) |=>
            ((cause_q[p] & $past(prdata_q[7:0]) & SC_ERR_BITS) == 8'h00))
            else $error("stop cause survived read");
         excess_col_a: assert property (@(posedge i_clock) disable iff (!i_rstn)
            (i_tx_excess_col[p] && txpol_q[p][SC_EXCESS_COL]) |=> cause_q[p][SC_EXCESS_COL])
            else $error("excess collision not recorded");
         starved_fifo_a: assert property (@(posedge i_clock) disable iff (!i_rstn)
            (i_tx_starved[p] && txpol_q[p][SC_STARVED]) |=> cause_q[p][SC_STARVED])
            else $error("fifo starvation not recorded");
         pkc_inc_a: assert property (@(posedge i_clock) disable iff (!i_rstn)
            (i_tx_fifo_first_byte[p] && !i_tx_done[p] && (pkc_q[p] != PKC_MAX)) |=>
            (pkc_q[p] == $past(pkc_q[p]) + 2'h1))
            else $error("packet count not incremented");
         pkc_dec_a: assert property (@(posedge i_clock) disable iff (!i_rstn)
            (i_tx_done[p] && !i_tx_fifo_first_byte[p] && (pkc_q[p] != 2'h0)) |=>
            (pkc_q[p] == $past(pkc_q[p]) - 2'h1))
            else $error("packet count not decremented");
         sat_keep_a: assert property (@(posedge i_clock) disable iff (!i_rstn)
            (rd_flags && i_counter_saturated[p] && mask_q[p][FLG_SATURATED]) |=> flags_q[p][FLG_SATURATED])
            else $error("saturated counter flag cleared");
         mask_rsv_a: assert property (@(posedge i_clock) disable iff (!i_rstn)
            ((mask_q[p] & ~MASK_VALID) == 8'h00) && ((flags_q[p] & ~MASK_VALID) == 8'h00))
            else $error("reserved bit set");
      end
   endgenerate

   assign o_irq = summary != '0;

   irq_sum_a: assert property (@(posedge i_clock) disable iff (!i_rstn)
      o_irq == (flags_q[0] != 8'h00 || summary[NUM_PORTS-1:1] != '0))
      else $error("irq does not follow summary");

   bad_read_a: assert property (@(posedge i_clock) disable iff (!i_rstn)
      (i_psel && !i_penable && !i_pwrite && addr_bad) |=> (o_prdata == RDATA_ZERO))
      else $error("refused read returned data");
   summary_err_a: assert property (@(posedge i_clock) disable iff (!i_rstn)
      (acc && (sel_idx == IDX_SUMMARY) && (sel_port != '0)) |-> o_pslverr)
      else $error("summary access off port 0 accepted");

endmodule

// [testbench.sv]
// Self-checking testbench for the port event interrupt block.
`timescale 1ns/1ps
module testbench;
   import pei_pkg::*;
   logic        clk = 0, rstn = 0, psel = 0, pen = 0, pwr = 0;
   logic [31:0] pa = 0, pwd = 0, prd;
   logic        pready, pslverr, irq;
   logic [7:0]  evs [9];
   logic [7:0]  rxc [8];
   logic [7:0]  txi = 8'hff, rxi = 8'hff, symbol_link_mode = 8'h00, tpe, rpe;
   int          err_total = 0, cmp_count = 0;

   always #2.5 clk = ~clk;

   pei_top pei_top_i (.i_clock(clk), .i_rstn(rstn), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
      .i_paddr(pa), .i_pwdata(pwd), .o_prdata(prd), .o_pready(pready), .o_pslverr(pslverr),
      .i_rx_good_done(evs[0]), .i_rx_pkt_end(evs[1]), .i_rx_cause(rxc), .i_tx_done(evs[2]),
      .i_tx_excess_col(evs[3]), .i_tx_late_col(evs[4]), .i_tx_starved(evs[5]),
      .i_tx_fifo_first_byte(evs[6]), .i_tx_idle(txi), .i_rx_idle(rxi), .i_counter_saturated(evs[7]),
      .i_link_changed(evs[8]), .i_symbol_link_mode(symbol_link_mode), .o_transmit_path_enable(tpe),
      .o_receive_path_enable(rpe), .o_receive_filter_policy(), .o_irq(irq));

   task automatic stop_test;
      $display("compares %0d mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   task automatic bad(input string s);
      $display("wrong value at %0t: %s", $time, s);
      err_total++;
   endtask

   task automatic chk8(input logic [7:0] g, input logic [7:0] e, input string s);
      cmp_count++;
      if (g !== e) bad($sformatf("%s got %h want %h", s, g, e));
   endtask

   task automatic chk1(input logic g, input logic e, input string s);
      cmp_count++;
      if (g !== e) bad($sformatf("%s got %b want %b", s, g, e));
   endtask

   function automatic logic [31:0] ad(input logic [2:0] p, input logic [2:0] idx);
      return {24'h0, p, idx, 2'b00};
   endfunction

   // Flags expected from the good receive, transmit done, link and saturation events.
   function automatic logic [7:0] exp_flags(input logic [7:0] m);
      return m & 8'h35;
   endfunction

   function automatic logic [7:0] exp_sum(input logic [2:0] p, input logic f);
      return f ? (8'h01 << p) : 8'h00;
   endfunction

   // One APB transfer; read data and error are taken at the edge that sees pready high.
   task automatic apb(input logic w, input logic [31:0] a, input logic [7:0] wd,
                      output logic [7:0] rd, output logic er);
      int n;
      @(posedge clk);
      psel <= 1'b1; pen <= 1'b0; pwr <= w; pa <= a; pwd <= {24'h0, wd};
      @(posedge clk);
      pen <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 40);
      if (n >= 40) begin
         bad("bus timeout");
         stop_test();
      end
      rd = prd[7:0];
      er = pslverr;
      psel <= 1'b0;
      pen <= 1'b0;
   endtask

   task automatic wr(input logic [2:0] p, input logic [2:0] idx, input logic [7:0] d);
      logic [7:0] r;
      logic       e;
      apb(1'b1, ad(p, idx), d, r, e);
      chk1(e, 1'b0, "write error");
   endtask

   task automatic rc(input logic [2:0] p, input logic [2:0] idx, input logic [7:0] x);
      logic [7:0] r;
      logic       e;
      apb(1'b0, ad(p, idx), 8'h00, r, e);
      chk8(r, x, $sformatf("port %0d reg %0d", p, idx));
      chk1(e, 1'b0, "read error");
   endtask

   task automatic pulse(input int k, input logic [2:0] p);
      @(posedge clk);
      evs[k][p] <= 1'b1;
      @(posedge clk);
      evs[k][p] <= 1'b0;
      repeat (2) @(posedge clk);
   endtask

   task automatic run(input logic [2:0] p);
      logic [7:0] m, r;
      logic       e;
      m = 8'($urandom);
      wr(p, IDX_MASK, m);
      rc(p, IDX_MASK, m & MASK_VALID);
      @(posedge clk) symbol_link_mode[p] <= 1'b1;
      pulse(2, p); pulse(0, p); pulse(8, p); pulse(7, p);
      rc(0, IDX_SUMMARY, exp_sum(p, |exp_flags(m)));
      chk1(irq, |exp_flags(m), "irq set");
      rc(p, IDX_FLAGS, exp_flags(m));
      rc(p, IDX_FLAGS, 8'h00);
      rc(0, IDX_SUMMARY, 8'h00);
      chk1(irq, 1'b0, "irq clear");
      wr(p, IDX_MASK, 8'h7f);
      @(posedge clk) symbol_link_mode[p] <= 1'b0;
      pulse(8, p);
      rc(p, IDX_FLAGS, 8'h00);
      wr(p, IDX_TXPOLICY, SC_ERR_BITS);
      pulse(3, p); pulse(4, p); pulse(5, p);
      rc(p, IDX_FLAGS, 8'h08);
      rc(p, IDX_FLAGS, 8'h08);
      rc(p, IDX_STOPCAUSE, SC_ERR_BITS);
      rc(p, IDX_STOPCAUSE, 8'h00);
      rc(p, IDX_FLAGS, 8'h00);
      wr(p, IDX_TXPOLICY, 8'h00);
      pulse(3, p);
      rc(p, IDX_STOPCAUSE, 8'h00);
      r = (8'($urandom) & RX_CAUSE_VALID) | 8'h01;
      @(posedge clk) rxc[p] <= r;
      pulse(1, p);
      rc(p, IDX_FLAGS, 8'h02);
      rc(p, IDX_RXCAUSE, r);
      rc(p, IDX_RXCAUSE, 8'h00);
      rc(p, IDX_FLAGS, 8'h00);
      repeat (3) pulse(6, p);
      rc(p, IDX_STOPCAUSE, 8'h80);
      pulse(2, p);
      rc(p, IDX_STOPCAUSE, 8'h40);
      rc(p, IDX_FLAGS, 8'h04);
      wr(p, IDX_CONTROL, 8'h18);
      @(posedge clk);
      chk1(tpe[p] & rpe[p], 1'b1, "path enables");
      @(posedge clk) txi[p] <= 1'b0;
      wr(p, IDX_CONTROL, 8'h00);
      rc(p, IDX_FLAGS, 8'h00);
      @(posedge clk) txi[p] <= 1'b1;
      repeat (3) @(posedge clk);
      rc(p, IDX_FLAGS, 8'h40);
      @(posedge clk) evs[7][p] <= 1'b1;
      repeat (2) @(posedge clk);
      rc(p, IDX_FLAGS, 8'h20);
      rc(p, IDX_FLAGS, 8'h20);
      @(posedge clk) evs[7][p] <= 1'b0;
      rc(p, IDX_FLAGS, 8'h20);
      rc(p, IDX_FLAGS, 8'h00);
      if (p != 3'h0) begin
         apb(1'b0, ad(p, IDX_SUMMARY), 8'h00, r, e);
         chk1(e, 1'b1, "summary off port 0");
      end
      $display("test port %0d done", p);
   endtask

   initial begin
      logic [7:0] r;
      logic       e;
      foreach (evs[i]) evs[i] = 8'h00;
      foreach (rxc[i]) rxc[i] = 8'h00;
      void'($urandom(32'hb4da6a5f));
      repeat (3) @(posedge clk);
      rstn <= 1'b1;
      for (int p = 0; p < NUM_PORTS; p++) begin
         rc(3'(p), IDX_MASK, REG_RESET);
         rc(3'(p), IDX_STOPCAUSE, REG_RESET);
      end
      $display("test reset values done");
      for (int p = 0; p < NUM_PORTS; p++) run(3'(p));
      apb(1'b0, 32'h0000_0100, 8'h00, r, e);
      chk1(e, 1'b1, "unmapped address");
      $display("test unmapped done");
      stop_test();
   end
endmodule
